/* design/scr_sysref_clock_status_regs.v */
`timescale 1ns/10ps
`include "scr_regs.vh"
module scr_sysref_clock_status_regs
(
  input  wire                    i_clk_sys,
  input  wire                    i_sys_rst,
  input  wire                    i_wr_en,
  input  wire                    i_rd_en,
  input  wire [`SCR_ADDR_W-1:0]  i_addr,
  input  wire [7:0]              i_wr_data,
  output reg  [7:0]              o_rd_data,
  output reg                     o_rd_valid,
  input  wire                    i_sysref,
  input  wire                    i_marginal_capture,
  output wire [3:0]              o_sysref_delay_steps,
  output wire                    o_sync_diff_powerdown,
  output wire                    o_input_clamp_en,
  output wire [3:0]              o_preemph_strength,
  output wire [7:0]              o_gen_ctl0
);

  // Slots of the two asynchronous pins in the filter vectors.
  localparam integer PIN_SREF = 0;
  localparam integer PIN_MARG = 1;
  localparam integer N_PINS   = 2;

  reg  [7:0]        ctl0_q;
  reg  [7:0]        ctl0_d;
  reg  [7:0]        ctl2_q;
  reg  [7:0]        ctl2_d;
  reg  [7:0]        misc_q;
  reg  [7:0]        misc_d;
  reg  [7:0]        clamp_q;
  reg  [7:0]        clamp_d;
  reg  [7:0]        ser_q;
  reg  [7:0]        ser_d;
  reg               seen_q;
  reg               seen_d;
  reg               marg_q;
  reg               marg_d;
  reg  [7:0]        stat_word;
  reg  [7:0]        rd_d;
  wire [N_PINS-1:0] pin_raw;
  wire [N_PINS-1:0] pin_lvl;
  wire [N_PINS-1:0] pin_rise;
  wire              sref_rise;
  wire              marg_rise;
  wire              sref_lvl;
  wire              marg_lvl;
  wire              marg_set;
  wire              seen_clr_fall;
  wire              marg_clr_fall;
  wire              wr_ctl0;
  wire              wr_ctl2;
  wire              wr_misc;
  wire              wr_clamp;
  wire              wr_ser;
  genvar            gi;

  assign pin_raw[PIN_SREF] = i_sysref;
  assign pin_raw[PIN_MARG] = i_marginal_capture;

  // External pins pass three stages; a change counts once stages two and three agree.
  generate
    for (gi = 0; gi < N_PINS; gi = gi + 1)
    begin : g_pin_filter
      reg  [2:0] sync_q;
      reg        lvl_q;
      wire       agree;

      assign agree = (sync_q[1] == sync_q[2]);

      always @(posedge i_clk_sys or posedge i_sys_rst)
      begin
        if (i_sys_rst)
        begin
          sync_q <= 3'h0;
          lvl_q  <= 1'b0;
        end
        else
        begin
          sync_q <= {sync_q[1:0], pin_raw[gi]};
          if (agree)
          begin
            lvl_q <= sync_q[2];
          end
        end
      end

      // Reset leaves the level low like the idle pins, so no false edge follows reset.
      assign pin_lvl[gi]  = lvl_q;
      assign pin_rise[gi] = agree && sync_q[2] && !lvl_q;
    end
  endgenerate

  assign sref_rise = pin_rise[PIN_SREF];
  assign marg_rise = pin_rise[PIN_MARG];
  assign sref_lvl  = pin_lvl[PIN_SREF];
  assign marg_lvl  = pin_lvl[PIN_MARG];

  // The status address has no write strobe, so a write to it changes nothing.
  assign wr_ctl0  = i_wr_en && (i_addr == `SCR_OFF_GEN_CTL0);
  assign wr_ctl2  = i_wr_en && (i_addr == `SCR_OFF_GEN_CTL2);
  assign wr_misc  = i_wr_en && (i_addr == `SCR_OFF_ANALOG_MISC_CONTROL);
  assign wr_clamp = i_wr_en && (i_addr == `SCR_OFF_CLAMP);
  assign wr_ser   = i_wr_en && (i_addr == `SCR_OFF_SERIALIZER_CONFIG);

  always @*
  begin
    ctl0_d = ctl0_q;
    if (wr_ctl0)
    begin
      ctl0_d = i_wr_data;
    end
  end

  always @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      ctl0_q <= `SCR_RST_GEN_CTL0;
    end
    else
    begin
      ctl0_q <= ctl0_d;
    end
  end

  always @*
  begin
    ctl2_d = ctl2_q;
    if (wr_ctl2)
    begin
      ctl2_d = i_wr_data;
    end
  end

  always @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      ctl2_q <= `SCR_RST_GEN_CTL2;
    end
    else
    begin
      ctl2_q <= ctl2_d;
    end
  end

  always @*
  begin
    misc_d = misc_q;
    if (wr_misc)
    begin
      misc_d = i_wr_data;
    end
  end

  always @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      misc_q <= `SCR_RST_ANALOG_MISC_CONTROL;
    end
    else
    begin
      misc_q <= misc_d;
    end
  end

  always @*
  begin
    clamp_d = clamp_q;
    if (wr_clamp)
    begin
      clamp_d = i_wr_data;
    end
  end

  always @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      clamp_q <= `SCR_RST_CLAMP;
    end
    else
    begin
      clamp_q <= clamp_d;
    end
  end

  always @*
  begin
    ser_d = ser_q;
    if (wr_ser)
    begin
      ser_d = i_wr_data;
    end
  end

  always @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      ser_q <= `SCR_RST_SERIALIZER_CONFIG;
    end
    else
    begin
      ser_q <= ser_d;
    end
  end

  // The clear acts on the one-to-zero write, so a flag is clear only after both writes.
  assign seen_clr_fall = wr_ctl0 && ctl0_q[`SCR_BIT_SEEN_CLR]
                         && !i_wr_data[`SCR_BIT_SEEN_CLR];
  assign marg_clr_fall = wr_ctl0 && ctl0_q[`SCR_BIT_MARG_CLR]
                         && !i_wr_data[`SCR_BIT_MARG_CLR];

  // The detector may settle after the edge, so its late rise while SYSREF is high counts too.
  assign marg_set = (sref_rise && marg_lvl) || (marg_rise && sref_lvl);

  // A new event in the clearing cycle wins, so no event is lost.
  always @*
  begin
    seen_d = seen_q;
    if (sref_rise)
    begin
      seen_d = 1'b1;
    end
    else if (seen_clr_fall)
    begin
      seen_d = 1'b0;
    end
  end

  always @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      seen_q <= 1'b0;
    end
    else
    begin
      seen_q <= seen_d;
    end
  end

  always @*
  begin
    marg_d = marg_q;
    if (marg_set)
    begin
      marg_d = 1'b1;
    end
    else if (marg_clr_fall)
    begin
      marg_d = 1'b0;
    end
  end

  always @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      marg_q <= 1'b0;
    end
    else
    begin
      marg_q <= marg_d;
    end
  end

  // The low bits are a fixed pattern; the two flags sit above it at their own positions.
  always @*
  begin
    stat_word                = {2'h0, `SCR_STAT_LOW};
    stat_word[`SCR_BIT_SEEN] = seen_q;
    stat_word[`SCR_BIT_MARG] = marg_q;
  end

  always @*
  begin
    case (i_addr)
      `SCR_OFF_GEN_CTL0: rd_d = ctl0_q;
      `SCR_OFF_GEN_STAT: rd_d = stat_word;
      `SCR_OFF_GEN_CTL2: rd_d = ctl2_q;
      `SCR_OFF_ANALOG_MISC_CONTROL: rd_d = misc_q;
      `SCR_OFF_CLAMP:    rd_d = clamp_q;
      `SCR_OFF_SERIALIZER_CONFIG:  rd_d = ser_q;
      default:           rd_d = 8'h00;
    endcase
  end

  always @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_rd_valid <= 1'b0;
    end
    else
    begin
      o_rd_valid <= i_rd_en;
    end
  end

  // Read data holds until the next read strobe, so a slow master may sample it late.
  always @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_rd_data <= 8'h00;
    end
    else if (i_rd_en)
    begin
      o_rd_data <= rd_d;
    end
  end

  // Each delay step is nominally SCR_STEP_PS picoseconds; the analog trim does the delaying.
  assign o_sysref_delay_steps  = ctl2_q[3:0];
  assign o_sync_diff_powerdown = misc_q[`SCR_BIT_SYNC_PD];
  assign o_input_clamp_en      = clamp_q[`SCR_BIT_CLAMP_EN];
  assign o_preemph_strength    = ser_q[3:0];
  assign o_gen_ctl0            = ctl0_q;

endmodule

/* include/scr_regs.vh */
// Function
// - A SYSREF rising edge sets bit 7 of the clock status register until it is cleared.
// - The SYSREF-seen flag clears only when its clear bit is written one and then zero.
// - The SYSREF-seen clear is bit 5 of the register at 0x030, read-write, reset zero.
// - A SYSREF edge too close to a device clock edge sets bit 6 of the clock status register.
// - The marginal-capture flag clears only after its clear bit goes to one and back to zero.
// - The marginal-capture clear is bit 4 of the register at 0x030, read-write, reset zero.
// - Bits 5 to 0 of the clock status register always read 000111b.
// - Control register 2 bits 3 to 0 set the SYSREF delay, 0 to 15 steps of 20 ps, reset 0.
// - Bit 2 of the analog miscellaneous register powers down the differential SYNC receiver.
// - Bit 5 of the input clamp register enables the input clamp and resets to one.
// - Bits 3 to 0 of the serializer register set pre-emphasis strength, reset four.
`ifndef SCR_REGS_VH
`define SCR_REGS_VH
`define SCR_ADDR_W        12
`define SCR_OFF_GEN_CTL0  12'h030
`define SCR_OFF_GEN_STAT  12'h031
`define SCR_OFF_GEN_CTL2  12'h032
`define SCR_OFF_ANALOG_MISC_CONTROL  12'h033
`define SCR_OFF_CLAMP     12'h034
`define SCR_OFF_SERIALIZER_CONFIG   12'h040
`define SCR_RST_GEN_CTL0  8'hc0
`define SCR_RST_GEN_CTL2  8'h80
`define SCR_RST_ANALOG_MISC_CONTROL  8'hc3
`define SCR_RST_CLAMP     8'h2f
`define SCR_RST_SERIALIZER_CONFIG   8'h04
`define SCR_STAT_LOW      6'h07
`define SCR_BIT_SEEN_CLR  5
`define SCR_BIT_MARG_CLR  4
`define SCR_BIT_SEEN      7
`define SCR_BIT_MARG      6
`define SCR_BIT_SYNC_PD   2
`define SCR_BIT_CLAMP_EN  5
`define SCR_STEP_PS       20
`endif

/* testbench/scr_clk_src.sv */
`timescale 1ns/10ps
module scr_clk_src
(
  input  wire i_clk_sys,
  output reg  o_sysref,
  output reg  o_marginal
);
  initial o_sysref = 1'b0;
  initial o_marginal = 1'b0;
  // The marginal level leads the edge so the detector filter has settled first.
  task automatic fire(input logic marg);
    @(posedge i_clk_sys) #1 o_marginal = marg;
    repeat (4) @(posedge i_clk_sys);
    #1 o_sysref = 1'b1;
    repeat (6) @(posedge i_clk_sys);
    #1 o_sysref = 1'b0;
    o_marginal = 1'b0;
    repeat (4) @(posedge i_clk_sys);
  endtask
  // A slow detector: the marginal level rises only after SYSREF has settled high.
  task automatic late;
    @(posedge i_clk_sys) #1 o_sysref = 1'b1;
    repeat (5) @(posedge i_clk_sys);
    #1 o_marginal = 1'b1;
    repeat (6) @(posedge i_clk_sys);
    #1 o_sysref = 1'b0;
    o_marginal = 1'b0;
    repeat (4) @(posedge i_clk_sys);
  endtask
endmodule

/* testbench/scr_regs_monitor.sv */
`timescale 1ns/10ps
module scr_regs_monitor
(
  input wire        i_clk_sys,
  input wire        i_sys_rst,
  input wire        i_wr_en,
  input wire        i_rd_en,
  input wire [11:0] i_addr,
  input wire [7:0]  i_wr_data,
  input wire [7:0]  o_rd_data,
  input wire        o_rd_valid,
  input wire [3:0]  o_sysref_delay_steps,
  input wire        o_sync_diff_powerdown,
  input wire        o_input_clamp_en,
  input wire [3:0]  o_preemph_strength,
  input wire [7:0]  o_gen_ctl0
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  rd_pulse_a: assert property (o_rd_valid == $past(i_rd_en)) else $error("valid mistimed");
  stat_low_a: assert property (
    i_rd_en && i_addr == 12'h031 |=> o_rd_data[5:0] == 6'h07) else $error("status low");
  ctl0_wr_a: assert property (
    i_wr_en && i_addr == 12'h030 |=> o_gen_ctl0 == $past(i_wr_data)) else $error("ctl0");
  delay_wr_a: assert property (
    i_wr_en && i_addr == 12'h032 |=> o_sysref_delay_steps == $past(i_wr_data[3:0]))
    else $error("delay");
  sync_pd_a: assert property (
    i_wr_en && i_addr == 12'h033 |=> o_sync_diff_powerdown == $past(i_wr_data[2]))
    else $error("powerdown");
  clamp_wr_a: assert property (
    i_wr_en && i_addr == 12'h034 |=> o_input_clamp_en == $past(i_wr_data[5])) else $error("clamp");
  preemph_wr_a: assert property (
    i_wr_en && i_addr == 12'h040 |=> o_preemph_strength == $past(i_wr_data[3:0]))
    else $error("preemph");
  unmapped_rd_a: assert property (
    i_rd_en && i_addr == 12'h035 |=> o_rd_data == 8'h00) else $error("unmapped");
endmodule
bind scr_sysref_clock_status_regs scr_regs_monitor i_mon (.*);

/* testbench/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0, rst = 1'b1, we = 1'b0, re = 1'b0, rv, sr, mc, pd, ce;
  logic [11:0] a = 12'h000;
  logic [7:0]  wd = 8'h00, rdat, c0;
  logic [3:0]  dl, pe;
  int fails = 0, n_compared = 0;
  always #2.5 clk = ~clk;
  scr_clk_src i_src (.i_clk_sys(clk), .o_sysref(sr), .o_marginal(mc));
  scr_sysref_clock_status_regs i_dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_wr_en(we),
    .i_rd_en(re), .i_addr(a), .i_wr_data(wd), .o_rd_data(rdat), .o_rd_valid(rv),
    .i_sysref(sr), .i_marginal_capture(mc), .o_sysref_delay_steps(dl),
    .o_sync_diff_powerdown(pd), .o_input_clamp_en(ce), .o_preemph_strength(pe),
    .o_gen_ctl0(c0));
  task chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e)
    begin
      fails++;
      $display("Error %0t: got %h want %h", $time, s, e);
    end
  endtask
  task wr(input logic [11:0] ad, input logic [7:0] d);
    @(posedge clk) #1 we = 1'b1;
    a = ad;
    wd = d;
    @(posedge clk) #1 we = 1'b0;
  endtask
  task rd(input logic [11:0] ad, input logic [7:0] e);
    @(posedge clk) #1 re = 1'b1;
    a = ad;
    @(posedge clk) #1 re = 1'b0;
    chk({7'h00, rv}, 8'h01);
    chk(rdat, e);
  endtask
  task t_reset;
    rd(12'h031, 8'h07);
    rd(12'h030, 8'hc0);
    rd(12'h032, 8'h80);
    rd(12'h033, 8'hc3);
    rd(12'h034, 8'h2f);
    rd(12'h040, 8'h04);
    $display("t_reset done");
  endtask
  task t_rw;
    wr(12'h032, 8'h8f);
    wr(12'h033, 8'hc7);
    wr(12'h034, 8'h0f);
    wr(12'h040, 8'h0a);
    chk({dl, pe}, 8'hfa);
    chk({6'h00, pd, ce}, 8'h02);
    wr(12'h033, 8'hc3);
    chk({7'h00, pd}, 8'h00);
    wr(12'h035, 8'h55);
    rd(12'h035, 8'h00);
    rd(12'h032, 8'h8f);
    wr(12'h031, 8'hff);
    rd(12'h031, 8'h07);
    $display("t_rw done");
  endtask
  task t_seen;
    wr(12'h032, 8'h81);
    i_src.fire(1'b0);
    rd(12'h031, 8'h87);
    wr(12'h031, 8'h00);
    rd(12'h031, 8'h87);
    wr(12'h030, 8'he0);
    chk(c0, 8'he0);
    rd(12'h031, 8'h87);
    wr(12'h030, 8'hc0);
    rd(12'h031, 8'h07);
    $display("t_seen done");
  endtask
  task t_marg;
    i_src.fire(1'b1);
    rd(12'h031, 8'hc7);
    wr(12'h030, 8'hd0);
    wr(12'h030, 8'hc0);
    rd(12'h031, 8'h87);
    $display("t_marg done");
  endtask
  task t_late;
    i_src.late;
    rd(12'h031, 8'hc7);
    wr(12'h030, 8'hf0);
    chk(c0, 8'hf0);
    wr(12'h030, 8'hc0);
    rd(12'h031, 8'h07);
    $display("t_late done");
  endtask
  task report_and_stop;
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    t_reset;
    t_rw;
    t_seen;
    t_marg;
    t_late;
    report_and_stop;
  end
  initial
  begin
    #20000;
    fails++;
    report_and_stop;
  end
endmodule
